// >>> bench/irq_status0_peek_view_bench.sv
// Self-checking bench for the status byte peek view.
`timescale 1ns/1ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin bad_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, got, exp); end end

module irq_status0_peek_view_bench;
  import ispv_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [7:0] evt = 8'h00;
  logic [7:0] addr, wdata, rdata, irq, d, d2, exp_flags;
  logic rd, wr, rvalid, v;
  int bad_count = 0;
  int samples_checked = 0;

  // ==========================================================================
  // Clock at 20 MHz and the design under test with its host.
  always #25 i_core_clk = ~i_core_clk;

  ispv_peek_view ispv_peek_view_i (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .i_reg_addr(addr), .i_reg_rd(rd), .i_reg_wr(wr), .i_reg_wdata(wdata),
    .i_evt_end_of_packet(evt[7]), .i_evt_rx_buffer_empty(evt[6]),
    .i_evt_self_init_done(evt[5]), .i_evt_osc_ready(evt[4]),
    .i_evt_nvm_write_erase_done(evt[3]), .i_evt_packet_sent(evt[2]),
    .i_evt_rx_buffer_full(evt[1]), .i_evt_packet_received(evt[0]),
    .o_reg_rdata(rdata), .o_rd_valid(rvalid), .o_irq_status0(irq));

  ispv_host_model ispv_host_model_i (.i_core_clk(i_core_clk), .i_reg_rdata(rdata),
    .i_rd_valid(rvalid), .o_reg_addr(addr), .o_reg_rd(rd), .o_reg_wr(wr),
    .o_reg_wdata(wdata));

  // ==========================================================================
  // Peek read compared against the expected flag byte and the live flags.
  task automatic peek_check(input logic [7:0] e);
    ispv_host_model_i.rd(ISPV_PEEK_ADDR, d, v);
    `CHK(v, 1'b1)
    `CHK(d, e)
    `CHK(irq, e)
  endtask : peek_check

  // Flags come out of reset clear.
  task automatic t_reset();
    `CHK(irq, ISPV_PEEK_RESET)
    peek_check(8'h00);
  endtask : t_reset

  // Each event sets only its own bit; repeated peeks leave flags standing.
  task automatic t_each_flag();
    exp_flags = 8'h00;
    for (int b = 0; b < ISPV_FLAG_COUNT; b++) begin
      @(negedge i_core_clk);
      evt = 8'h01 << b;
      @(negedge i_core_clk);
      evt = 8'h00;
      exp_flags = exp_flags | (8'h01 << b);
      peek_check(exp_flags);
      peek_check(exp_flags);
    end
  endtask : t_each_flag

  // Writes to the peek and clear addresses change nothing.
  task automatic t_write_ignored();
    ispv_host_model_i.wr(ISPV_PEEK_ADDR, 8'h00);
    ispv_host_model_i.wr(ISPV_CLEAR_ADDR, 8'h00);
    peek_check(8'hFF);
  endtask : t_write_ignored

  // Companion read clears all flags except those whose events coincide.
  task automatic t_clear();
    @(negedge i_core_clk);
    evt = 8'h0C;
    ispv_host_model_i.rd(ISPV_CLEAR_ADDR, d, v);
    evt = 8'h00;
    `CHK(d, 8'hFF)
    peek_check(8'h0C);
    ispv_host_model_i.rd2(ISPV_CLEAR_ADDR, ISPV_PEEK_ADDR, d, d2);
    `CHK(d, 8'h0C)
    `CHK(d2, 8'h00)
    peek_check(8'h00);
    ispv_host_model_i.rd(8'h10, d, v);
    `CHK(d, ISPV_UNMAPPED_DATA)
    `CHK(v, 1'b1)
  endtask : t_clear

  // A reset in mid-run drops every flag and the held read answer.
  task automatic t_mid_reset();
    @(negedge i_core_clk);
    evt = 8'hFF;
    @(negedge i_core_clk);
    evt = 8'h00;
    peek_check(8'hFF);
    i_rst_n = 1'b0;
    repeat (3) @(negedge i_core_clk);
    i_rst_n = 1'b1;
    `CHK(irq, ISPV_PEEK_RESET)
    `CHK(rdata, ISPV_PEEK_RESET)
    `CHK(rvalid, 1'b0)
    peek_check(8'h00);
  endtask : t_mid_reset

  // ==========================================================================
  // Verdict and end of run.
  task automatic wrap_up();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up

  // Watchdog: the tests need about a hundred cycles; the limit is twenty times that.
  initial begin
    #100000;
    bad_count++;
    wrap_up();
  end

  // Main sequence: three cycles of reset, then the scenarios.
  initial begin
    repeat (3) @(negedge i_core_clk);
    i_rst_n = 1'b1;
    t_reset();
    t_each_flag();
    t_write_ignored();
    t_clear();
    t_mid_reset();
    wrap_up();
  end
endmodule : irq_status0_peek_view_bench

// >>> bench/ispv_host_model.sv
// Host model that reads and writes the peek view over its register bus.
`timescale 1ns/1ps

module ispv_host_model (
  input wire logic i_core_clk,
  input wire logic [7:0] i_reg_rdata,
  input wire logic i_rd_valid,
  output logic [7:0] o_reg_addr,
  output logic o_reg_rd,
  output logic o_reg_wr,
  output logic [7:0] o_reg_wdata
);
  // ==========================================================================
  // Bus idle state at time zero.
  initial begin
    o_reg_addr = 8'h00;
    o_reg_rd = 1'b0;
    o_reg_wr = 1'b0;
    o_reg_wdata = 8'h00;
  end

  // ==========================================================================
  // One read: strobe for one cycle, answer sampled one cycle later.
  // Address is inverted on release so a stale value can never match.
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(negedge i_core_clk);
    o_reg_addr = a;
    o_reg_rd = 1'b1;
    @(negedge i_core_clk);
    o_reg_rd = 1'b0;
    o_reg_addr = ~a;
    d = i_reg_rdata;
    v = i_rd_valid;
  endtask : rd

  // Two reads back to back: the strobe stays up while the address moves on.
  task automatic rd2(input logic [7:0] a1, input logic [7:0] a2, output logic [7:0] d1,
                     output logic [7:0] d2);
    @(negedge i_core_clk);
    o_reg_addr = a1;
    o_reg_rd = 1'b1;
    @(negedge i_core_clk);
    o_reg_addr = a2;
    d1 = i_reg_rdata;
    @(negedge i_core_clk);
    o_reg_rd = 1'b0;
    o_reg_addr = ~a2;
    d2 = i_reg_rdata;
  endtask : rd2

  // One write: the device is expected to ignore it.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_core_clk);
    o_reg_addr = a;
    o_reg_wdata = d;
    o_reg_wr = 1'b1;
    @(negedge i_core_clk);
    o_reg_wr = 1'b0;
    o_reg_addr = ~a;
    o_reg_wdata = ~d;
  endtask : wr
endmodule : ispv_host_model

// >>> core/ispv_flag_cell.sv
// One sticky event flag with synchronous clear where a new event beats the clear.
`timescale 1ns/1ps

module ispv_flag_cell (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_set,
  input wire logic i_clear,
  output logic o_flag
);

  logic next_flag;

  // An event in the clearing cycle keeps the flag up so it is never lost.
  always_comb begin
    if (i_set) begin
      next_flag = 1'b1;
    end else if (i_clear) begin
      next_flag = 1'b0;
    end else begin
      next_flag = o_flag;
    end
  end

  // Flag register, cleared by the synchronous reset.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_flag <= 1'b0;
    end else begin
      o_flag <= next_flag;
    end
  end

endmodule : ispv_flag_cell

// >>> core/ispv_peek_view.sv
// First interrupt status byte with its clear-on-read port and its read-only peek view.
`timescale 1ns/1ps

// Summary of operation
// R01: Reading the peek copy of the first interrupt status byte never changes any flag.
// R02: The peek register answers at address 0x76 and reads all zeros after reset.
// R03: Bit 6 reads 1 once the receive buffer has gone empty since the last clear.
// R04: Bit 5 reads 1 once self initialization has completed since the last clear.
// R05: Bit 4 reads 1 once the oscillator has become ready since the last clear.
// R06: Bit 3 reads 1 once a non-volatile write or erase has completed since the last clear.
// R07: Bit 7 marks the last byte of a packet read and bit 0 marks a packet received.
// R08: Bit 2 marks a packet sent and bit 1 marks a full receive buffer or packet overflow.
// R09: The peek shows the same flags as the clear-on-read register whose read clears all eight except any whose event arrives in that cycle.
// R10: Host writes to the peek address are ignored and leave every flag alone.
module ispv_peek_view
  import ispv_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_rd,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_evt_end_of_packet,
  input wire logic i_evt_rx_buffer_empty,
  input wire logic i_evt_self_init_done,
  input wire logic i_evt_osc_ready,
  input wire logic i_evt_nvm_write_erase_done,
  input wire logic i_evt_packet_sent,
  input wire logic i_evt_rx_buffer_full,
  input wire logic i_evt_packet_received,
  output logic [7:0] o_reg_rdata,
  output logic o_rd_valid,
  output logic [7:0] o_irq_status0
);

  // ==========================================================================
  // Event gathering and address decode.
  logic [7:0] evt_vec;
  logic [7:0] flags;
  logic peek_rd;
  logic clear_rd;
  logic peek_wr;
  logic [7:0] next_rdata;
  logic next_rd_valid;

  // R07 packet read flags
  // R08 transmit and full flags
  // Each event pulse lands on its own bit of the status byte.
  always_comb begin
    evt_vec = 8'h00;
    evt_vec[ISPV_BIT_END_OF_PACKET] = i_evt_end_of_packet;
    evt_vec[ISPV_BIT_RX_BUFFER_EMPTY] = i_evt_rx_buffer_empty;
    evt_vec[ISPV_BIT_SELF_INIT_DONE] = i_evt_self_init_done;
    evt_vec[ISPV_BIT_OSC_READY] = i_evt_osc_ready;
    evt_vec[ISPV_BIT_NVM_WRITE_ERASE_DONE] = i_evt_nvm_write_erase_done;
    evt_vec[ISPV_BIT_PACKET_SENT] = i_evt_packet_sent;
    evt_vec[ISPV_BIT_RX_BUFFER_FULL] = i_evt_rx_buffer_full;
    evt_vec[ISPV_BIT_PACKET_RECEIVED] = i_evt_packet_received;
  end

  // Strobes qualified by address; only the companion read clears anything.
  assign peek_rd = i_reg_rd && (i_reg_addr == ISPV_PEEK_ADDR);
  assign clear_rd = i_reg_rd && (i_reg_addr == ISPV_CLEAR_ADDR);
  // The write data is deliberately dropped; the peek has no writable bits.
  assign peek_wr = i_reg_wr && (i_reg_addr == ISPV_PEEK_ADDR) && (i_reg_wdata == i_reg_wdata);

  // ==========================================================================
  // Shared sticky flags.
  // R03 R04 sticky flag set
  // R05 R06 sticky flag set
  // R09 clear on companion read
  // The peek and the clearing register share these cells, so they can never disagree.
  generate
    for (genvar g = 0; g < ISPV_FLAG_COUNT; g++) begin : g_flag
      ispv_flag_cell u_flag (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_set(evt_vec[g]),
        .i_clear(clear_rd),
        .o_flag(flags[g])
      );
    end
  endgenerate

  // ==========================================================================
  // Read data path.
  // R01 peek leaves flags
  // R02 peek address decode
  // Read data shows the flags as they stood before any clear in the same cycle.
  always_comb begin
    next_rd_valid = i_reg_rd;
    if (peek_rd) begin
      next_rdata = flags;
    end else if (clear_rd) begin
      next_rdata = flags;
    end else if (i_reg_rd) begin
      next_rdata = ISPV_UNMAPPED_DATA;
    end else begin
      next_rdata = o_reg_rdata;
    end
  end

  // R02 zero after reset
  // Registered answer keeps every output straight off a flip-flop.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_reg_rdata <= ISPV_PEEK_RESET;
      o_rd_valid <= 1'b0;
    end else begin
      o_reg_rdata <= next_rdata;
      o_rd_valid <= next_rd_valid;
    end
  end

  // R10 writes ignored
  // Nothing consumes peek_wr: the flags have no write path at all.
  assign o_irq_status0 = flags;

  // ==========================================================================
  // Checks on the flags and the read path.
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);

  sequence s_clear_quiet;
    clear_rd && (evt_vec == 8'h00);
  endsequence

  sequence s_peek_quiet;
    peek_rd && !clear_rd && (evt_vec == 8'h00);
  endsequence

  // R01 peek keeps flags
  a_peek_keeps_flags: assert property ( // R01
    peek_rd |=> (flags == ($past(flags) | $past(evt_vec))))
    else $error("Peek read changed the status flags.");

  // R02 reset clears all
  a_reset_all_zero: assert property ( // R02
    disable iff (1'b0) !i_rst_n |=> (o_reg_rdata == 8'h00) && (flags == 8'h00) && !o_rd_valid)
    else $error("Reset did not zero the peek register.");

  // R02 peek read answer
  a_peek_read_data: assert property ( // R02
    peek_rd |=> o_rd_valid && (o_reg_rdata == $past(flags)))
    else $error("Peek read did not return the flags one cycle later.");

  // R03 empty flag sets
  a_rx_empty_set: assert property ( // R03
    i_evt_rx_buffer_empty |=> flags[6] [*1] ##0 o_irq_status0[6])
    else $error("Receive empty event did not set bit 6.");

  // R04 self init flag
  a_self_init_set: assert property ( // R04
    i_evt_self_init_done |=> flags[5] && o_irq_status0[5])
    else $error("Self init event did not set bit 5.");

  // R05 oscillator flag sets
  a_osc_ready_set: assert property ( // R05
    $rose(i_evt_osc_ready) |=> flags[4])
    else $error("Oscillator ready event did not set bit 4.");

  // R06 write erase flag
  a_nvm_done_set: assert property ( // R06
    i_evt_nvm_write_erase_done && clear_rd |=> flags[3])
    else $error("Non-volatile done was lost against a clear.");

  // R07 packet read flags
  a_rx_packet_flags: assert property ( // R07
    (i_evt_end_of_packet || i_evt_packet_received) |=>
      (flags[7] || !$past(i_evt_end_of_packet)) && (flags[0] || !$past(i_evt_packet_received)))
    else $error("End of packet or packet received flag missing.");

  // R08 sent and full
  a_tx_full_flags: assert property ( // R08
    (i_evt_packet_sent || i_evt_rx_buffer_full) |=>
      (flags[2] || !$past(i_evt_packet_sent)) && (flags[1] || !$past(i_evt_rx_buffer_full)))
    else $error("Packet sent or buffer full flag missing.");

  // R09 companion clears all
  a_clear_all_flags: assert property ( // R09
    clear_rd |=> (flags == $past(evt_vec)) && (o_reg_rdata == $past(flags)))
    else $error("Companion read did not clear the flags.");

  // R09 peek after clear
  a_peek_after_clear: assert property ( // R09
    s_clear_quiet ##1 s_peek_quiet |=> (o_reg_rdata == 8'h00))
    else $error("Peek did not read zero after a quiet clear.");

  // R10 writes change nothing
  a_write_ignored: assert property ( // R10
    peek_wr && !clear_rd |=> (flags == ($past(flags) | $past(evt_vec))))
    else $error("Write to the peek address altered a flag.");

  // R02 valid only on reads
  a_valid_needs_read: assert property ( // R02
    !i_reg_rd |=> !o_rd_valid)
    else $error("Read valid rose without a read strobe.");

  // R02 answer holds between
  a_rdata_holds: assert property ( // R02
    !i_reg_rd |=> $stable(o_reg_rdata))
    else $error("Read data moved without a read strobe.");

  // R02 unmapped reads fill
  a_unmapped_fill: assert property ( // R02
    i_reg_rd && !peek_rd && !clear_rd |=>
      o_rd_valid && (o_reg_rdata == ISPV_UNMAPPED_DATA))
    else $error("Read at an unmapped address did not return the fill value.");

  // R03 flags stay set
  a_flags_sticky: assert property ( // R03
    !clear_rd |=> ((flags & $past(flags)) == $past(flags)))
    else $error("A status flag dropped without a clearing read.");

  // R05 only events set
  a_flags_need_event: assert property ( // R05
    (flags & ~($past(flags) | $past(evt_vec))) == 8'h00)
    else $error("A status flag rose without its event.");

  // R09 event beats clear
  a_set_beats_clear: assert property ( // R09
    clear_rd && (evt_vec != 8'h00) |=> ((flags & $past(evt_vec)) == $past(evt_vec)))
    else $error("An event that met a clearing read was lost.");

endmodule : ispv_peek_view

// >>> core/ispv_pkg.sv
// Package of addresses, reset values and bit positions for the status byte peek view.
package ispv_pkg;

  // ==========================================================================
  // Register addresses on the host parallel register bus.
  localparam logic [7:0] ISPV_PEEK_ADDR = 8'h76;
  localparam logic [7:0] ISPV_CLEAR_ADDR = 8'h63;

  // ==========================================================================
  // Reset values and widths.
  localparam int ISPV_FLAG_COUNT = 8;
  localparam logic [7:0] ISPV_PEEK_RESET = 8'h00;
  localparam logic [7:0] ISPV_UNMAPPED_DATA = 8'h00;

  // ==========================================================================
  // Flag positions inside the first interrupt status byte.
  localparam int ISPV_BIT_PACKET_RECEIVED = 0;
  localparam int ISPV_BIT_RX_BUFFER_FULL = 1;
  localparam int ISPV_BIT_PACKET_SENT = 2;
  localparam int ISPV_BIT_NVM_WRITE_ERASE_DONE = 3;
  localparam int ISPV_BIT_OSC_READY = 4;
  localparam int ISPV_BIT_SELF_INIT_DONE = 5;
  localparam int ISPV_BIT_RX_BUFFER_EMPTY = 6;
  localparam int ISPV_BIT_END_OF_PACKET = 7;

endpackage : ispv_pkg
